/* File: pkg/monitor_result_pkg.sv */
`default_nettype none
package monitor_result_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SYS_VOLTAGE_RESULT_HIGH_ADDR = 8'h1F;
  localparam logic [7:0] SYS_VOLTAGE_RESULT_LOW_ADDR = 8'h20;
  localparam logic [7:0] THERMISTOR_RATIO_RESULT_HIGH_ADDR = 8'h21;
  localparam logic [7:0] THERMISTOR_RATIO_RESULT_LOW_ADDR = 8'h22;
  localparam logic [7:0] DIE_TEMP_RESULT_HIGH_ADDR = 8'h23;
  localparam logic [7:0] DIE_TEMP_RESULT_LOW_ADDR = 8'h24;

  // ---------------------------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] RESULT_BYTE_RESET = 8'h00;
  localparam logic [15:0] RESULT_WORD_RESET = 16'h0000;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  localparam int RESULT_SIGN_BIT = 15;
  localparam int DIE_TEMP_FIELD_WIDTH = 15;
  localparam logic DIE_TEMP_RESERVED_VALUE = 1'b0;

  // ---------------------------------------------------------------
  // Register reset timing
  // ---------------------------------------------------------------
  localparam int REG_RESET_TIME_NS = 16;
  localparam int CLK_PERIOD_NS = 8;
  localparam int REG_RESET_CYCLES =
    (REG_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] REG_RESET_LAST =
    4'(REG_RESET_CYCLES - 1);

  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_CLEAR = 1'b1
  } reg_reset_state_t;

endpackage
`default_nettype wire

/* File: hdl/reg_reset_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module reg_reset_seq
  import monitor_result_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic request_i,
  output logic clear_o,
  output logic reset_bit_o
);
  import monitor_result_pkg::*;

  reg_reset_state_t state;
  reg_reset_state_t next_state;
  logic [3:0] count;
  logic [3:0] next_count;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_count = count;
    case (state)
      SEQ_IDLE:
      begin
        if (request_i)
        begin
          next_state = SEQ_CLEAR;
          next_count = 4'h0;
        end
      end
      SEQ_CLEAR:
      begin
        // Bit drops by itself once the clear is done
        if (count == REG_RESET_LAST)
        begin
          next_state = SEQ_IDLE;
        end
        else
        begin
          next_count = count + 4'h1;
        end
      end
      default:
      begin
        next_state = SEQ_IDLE;
        next_count = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= SEQ_IDLE;
      count <= 4'h0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign clear_o = (state == SEQ_CLEAR);
  assign reset_bit_o = (state == SEQ_CLEAR);

  AST_RST_BIT_CLEARS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(clear_o) |-> clear_o [*2] ##1 !reset_bit_o)
    else $error("reset bit did not clear after two cycles");

endmodule
`default_nettype wire

/* File: hdl/monitor_result_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module monitor_result_bank
  import monitor_result_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] sys_voltage_sample_i,
  input wire logic sys_voltage_valid_i,
  input wire logic [15:0] thermistor_ratio_sample_i,
  input wire logic thermistor_ratio_valid_i,
  input wire logic [14:0] die_temp_sample_i,
  input wire logic die_temp_valid_i,
  input wire logic reg_reset_request_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_read_i,
  input wire logic reg_write_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic reg_reset_bit_o
);
  import monitor_result_pkg::*;

  logic [15:0] sys_voltage_result;
  logic [15:0] thermistor_ratio_result;
  logic [14:0] die_temp_result;
  logic [15:0] next_sys_voltage_result;
  logic [15:0] next_thermistor_ratio_result;
  logic [14:0] next_die_temp_result;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic rvalid;
  logic next_rvalid;
  logic clear;

  // ---------------------------------------------------------------
  // Register reset sequencer
  // ---------------------------------------------------------------
  reg_reset_seq u_reg_reset_seq (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .request_i(reg_reset_request_i),
    .clear_o(clear),
    .reset_bit_o(reg_reset_bit_o)
  );

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  function automatic logic [7:0] read_byte(
    input logic [7:0] addr,
    input logic [15:0] sys_v,
    input logic [15:0] therm,
    input logic [14:0] temp
  );
    logic [7:0] data;
    data = UNMAPPED_READ_VALUE;
    case (addr)
      SYS_VOLTAGE_RESULT_HIGH_ADDR: data = sys_v[15:8];
      SYS_VOLTAGE_RESULT_LOW_ADDR: data = sys_v[7:0];
      THERMISTOR_RATIO_RESULT_HIGH_ADDR: data = therm[15:8];
      THERMISTOR_RATIO_RESULT_LOW_ADDR: data = therm[7:0];
      // Reserved top bit forced low whatever the sample held
      DIE_TEMP_RESULT_HIGH_ADDR:
        data = {DIE_TEMP_RESERVED_VALUE, temp[14:8]};
      DIE_TEMP_RESULT_LOW_ADDR: data = temp[7:0];
      default: data = UNMAPPED_READ_VALUE;
    endcase
    return data;
  endfunction

  // ---------------------------------------------------------------
  // Result capture
  // ---------------------------------------------------------------
  // Whole word is taken in one edge so the two bytes never tear.
  // Scaling is the converter's; the bank stores raw codes.
  always_comb
  begin
    next_sys_voltage_result = sys_voltage_result;
    next_thermistor_ratio_result = thermistor_ratio_result;
    next_die_temp_result = die_temp_result;
    if (clear)
    begin
      next_sys_voltage_result = RESULT_WORD_RESET;
      next_thermistor_ratio_result = RESULT_WORD_RESET;
      next_die_temp_result = RESULT_WORD_RESET[14:0];
    end
    else
    begin
      if (sys_voltage_valid_i)
      begin
        next_sys_voltage_result = sys_voltage_sample_i;
      end
      if (thermistor_ratio_valid_i)
      begin
        next_thermistor_ratio_result = thermistor_ratio_sample_i;
      end
      if (die_temp_valid_i)
      begin
        next_die_temp_result = die_temp_sample_i;
      end
    end
    // Write strobe and data deliberately feed nothing here
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sys_voltage_result <= RESULT_WORD_RESET;
      thermistor_ratio_result <= RESULT_WORD_RESET;
      die_temp_result <= RESULT_WORD_RESET[14:0];
    end
    else
    begin
      sys_voltage_result <= next_sys_voltage_result;
      thermistor_ratio_result <= next_thermistor_ratio_result;
      die_temp_result <= next_die_temp_result;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_comb
  begin
    next_rvalid = reg_read_i;
    next_rdata = rdata;
    if (reg_read_i)
    begin
      next_rdata = read_byte(reg_addr_i, sys_voltage_result,
        thermistor_ratio_result, die_temp_result);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata <= RESULT_BYTE_RESET;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_SYS_HIGH_READ: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_read_i && reg_addr_i == SYS_VOLTAGE_RESULT_HIGH_ADDR
    |=> reg_rvalid_o
      && reg_rdata_o == $past(sys_voltage_result[15:8]))
    else $error("system-rail high byte read wrong");

  AST_SYS_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sys_voltage_valid_i && !clear ##1 !sys_voltage_valid_i && !clear
    ##1 reg_read_i && reg_addr_i == SYS_VOLTAGE_RESULT_LOW_ADDR
      && !sys_voltage_valid_i && !clear
    |=> reg_rdata_o == $past(sys_voltage_sample_i[7:0], 3))
    else $error("system-rail low byte not captured");

  AST_THERM_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_read_i && reg_addr_i == THERMISTOR_RATIO_RESULT_HIGH_ADDR
    |=> reg_rdata_o == $past(thermistor_ratio_result[15:8]))
    else $error("thermistor high byte read wrong");

  AST_THERM_CAPTURE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    thermistor_ratio_valid_i && !clear
    |=> thermistor_ratio_result == $past(thermistor_ratio_sample_i))
    else $error("thermistor sample not stored");

  AST_THERM_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_read_i && reg_addr_i == THERMISTOR_RATIO_RESULT_LOW_ADDR
    |=> reg_rdata_o == $past(thermistor_ratio_result[7:0]))
    else $error("thermistor low byte read wrong");

  AST_TEMP_RESERVED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_read_i && reg_addr_i == DIE_TEMP_RESULT_HIGH_ADDR
    |=> !reg_rdata_o[7]
      && reg_rdata_o[6:0] == $past(die_temp_result[14:8]))
    else $error("die temperature high byte wrong");

  AST_TEMP_LOW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    die_temp_valid_i && !clear ##1 !die_temp_valid_i && !clear
    ##1 reg_read_i && reg_addr_i == DIE_TEMP_RESULT_LOW_ADDR
      && !die_temp_valid_i && !clear
    |=> reg_rdata_o == $past(die_temp_sample_i[7:0], 3))
    else $error("die temperature low byte wrong");

  AST_REG_RESET_ZERO: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !clear && reg_reset_request_i ##1 clear
    |=> sys_voltage_result == RESULT_WORD_RESET
      && thermistor_ratio_result == RESULT_WORD_RESET
      && die_temp_result == RESULT_WORD_RESET[14:0])
    else $error("register reset left a result set");

  AST_WRITE_IGNORED: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_write_i && !clear && !sys_voltage_valid_i
    |=> sys_voltage_result == $past(sys_voltage_result))
    else $error("host write changed a result");

  COV_SYS_READ: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    sys_voltage_valid_i
    ##2 reg_read_i && reg_addr_i == SYS_VOLTAGE_RESULT_HIGH_ADDR);
  COV_TEMP_READ: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    die_temp_valid_i
    ##2 reg_read_i && reg_addr_i == DIE_TEMP_RESULT_LOW_ADDR);
  COV_REG_RESET: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_reset_request_i ##1 clear ##2 !reg_reset_bit_o);
  COV_WRITE: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    reg_write_i && reg_addr_i == 8'h20);

endmodule
`default_nettype wire

/* File: testbench/host_reader.sv */
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_rvalid_i,
  output logic [7:0] reg_addr_o,
  output logic reg_read_o,
  output logic reg_write_o,
  output logic [7:0] reg_wdata_o
);
  // ------------------------------------------
  // Host side of the register port
  // ------------------------------------------
  initial
  begin
    reg_addr_o = 8'h00;
    reg_read_o = 1'b0;
    reg_write_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
  // Idle lines show the inverse, so stale values never match
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_read_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_read_o = 1'b0;
    reg_addr_o = ~a;
    ok = reg_rvalid_i;
    d = reg_rdata_i;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_write_o = 1'b1;
    @(posedge clk_i);
    #1;
    reg_write_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_monitor_adc_result_registers.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_monitor_adc_result_registers;
  import monitor_result_pkg::*;
  logic clk_i, rst_n_i, sv_v, th_v, dt_v, req, rd_en, wr_en, rvalid, rbit;
  logic [15:0] sv_s, th_s;
  logic [14:0] dt_s;
  logic [7:0] addr, wdata, rdata;
  int fails = 0;
  int n_checks = 0;
  int cycles = 0;
  monitor_result_bank u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sys_voltage_sample_i(sv_s), .sys_voltage_valid_i(sv_v),
    .thermistor_ratio_sample_i(th_s), .thermistor_ratio_valid_i(th_v),
    .die_temp_sample_i(dt_s), .die_temp_valid_i(dt_v),
    .reg_reset_request_i(req), .reg_addr_i(addr), .reg_read_i(rd_en),
    .reg_write_i(wr_en), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .reg_reset_bit_o(rbit));
  host_reader u_host (.clk_i(clk_i), .reg_rdata_i(rdata),
    .reg_rvalid_i(rvalid), .reg_addr_o(addr), .reg_read_o(rd_en),
    .reg_write_o(wr_en), .reg_wdata_o(wdata));
  // ------------------------------------------
  // Clock, run limit, report
  // ------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run needs under a hundred cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_host.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask
  task automatic put(input logic [15:0] s, t, input logic [14:0] d);
    @(posedge clk_i);
    #1;
    {sv_s, th_s, dt_s, sv_v, th_v, dt_v} = {s, t, d, 3'b111};
    @(posedge clk_i);
    #1;
    {sv_s, th_s, dt_s, sv_v, th_v, dt_v} = {~s, ~t, ~d, 3'b000};
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  task automatic t_reset_values();
    rdchk(8'h1F, 8'h00);
    rdchk(8'h20, 8'h00);
    rdchk(8'h21, 8'h00);
    rdchk(8'h22, 8'h00);
    rdchk(8'h23, 8'h00);
    rdchk(8'h24, 8'h00);
  endtask
  // Scale points: 10 V, half of the rail, 128 C, then 0.5 C
  task automatic t_capture();
    put(16'h2710, 16'h0200, 15'h0100);
    rdchk(8'h20, 8'h10);
    rdchk(8'h1F, 8'h27);
    rdchk(8'h21, 8'h02);
    rdchk(8'h23, 8'h01);
    put(16'h2710, 16'h0200, 15'h0001);
    rdchk(8'h24, 8'h01);
    rdchk(8'h23, 8'h00);
  endtask
  // Sign bit, full-scale fields, reserved top bit of temperature
  task automatic t_fields();
    put(16'h8001, 16'h03FF, 15'h7FFF);
    rdchk(8'h1F, 8'h80);
    rdchk(8'h20, 8'h01);
    rdchk(8'h21, 8'h03);
    rdchk(8'h22, 8'hFF);
    rdchk(8'h23, 8'h7F);
    rdchk(8'h24, 8'hFF);
    rdchk(8'h25, UNMAPPED_READ_VALUE);
  endtask
  task automatic t_writes();
    u_host.wr(8'h20, 8'hFE);
    u_host.wr(8'h23, 8'h80);
    rdchk(8'h20, 8'h01);
    rdchk(8'h23, 8'h7F);
  endtask
  // Pin reset in mid-run must zero every result as well
  task automatic t_hw_reset();
    put(16'h1234, 16'h0123, 15'h0456);
    rdchk(8'h20, 8'h34);
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk({7'h00, rbit}, 8'h00);
    t_reset_values();
  endtask
  // A sample offered during the clear must be dropped
  task automatic t_reg_reset();
    @(posedge clk_i);
    #1;
    req = 1'b1;
    @(posedge clk_i);
    #1;
    req = 1'b0;
    {sv_s, sv_v} = {16'h1234, 1'b1};
    chk({7'h00, rbit}, 8'h01);
    @(posedge clk_i);
    #1;
    sv_v = 1'b0;
    chk({7'h00, rbit}, 8'h01);
    @(posedge clk_i);
    #1;
    chk({7'h00, rbit}, 8'h00);
    rdchk(8'h1F, 8'h00);
    rdchk(8'h20, 8'h00);
    rdchk(8'h22, 8'h00);
    rdchk(8'h23, 8'h00);
  endtask
  initial
  begin
    {rst_n_i, req, sv_v, th_v, dt_v} = 5'b00000;
    {sv_s, th_s, dt_s} = '0;
    repeat (2) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset_values();
    t_capture();
    t_fields();
    t_writes();
    t_reg_reset();
    t_hw_reset();
    summarize();
  end
endmodule
`default_nettype wire
